// ### fcpwm_assertions.sv
// checker for the pwm core: bus answer, pin hand-over, reset values
// assumes it is bound to fcpwm_core and sees only its ports
module fcpwm_checker (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // register bus
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // port and pins
  input wire logic [3:0] PORT_DIR,
  input wire logic [3:0] PORT_DATA,
  input wire fcpwm_pkg::fcpwm_pins_s PWM_PINS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  // request taken, then exactly one answer cycle
  sequence s_take;
    (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_answer;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered after one wait");
  property p_stray;
    !WAITREQUEST |-> $past((READ || WRITE) && WAITREQUEST);
  endproperty
  a_stray: assert property (p_stray) else $error("answer without a request");
  property p_quiet;
    (!READ && !WRITE) [*2] |-> WAITREQUEST;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wait dropped while bus idle");
  property p_upper;
    READDATA[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data above byte not zero");
  property p_rd_hold;
    !$stable(READDATA) |-> $past(READ && WAITREQUEST);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_oe;
    $past(RST_B) |-> (~PWM_PINS.oe & $past(PORT_DIR)) == 4'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven although port says output");
  property p_level;
    $past(RST_B) |-> ((PWM_PINS.level ^ $past(PORT_DATA)) & ~PWM_PINS.oe) == 4'h0;
  endproperty
  a_level: assert property (p_level) else $error("idle pin level not from port data");
  property p_reset;
    $rose(RST_B) |-> WAITREQUEST && READDATA == 32'h00000000 && PWM_PINS == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind fcpwm_core fcpwm_checker u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .READ(READ), .WRITE(WRITE),
  .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .PORT_DIR(PORT_DIR), .PORT_DATA(PORT_DATA),
  .PWM_PINS(PWM_PINS));

// ### fcpwm_core.sv
// four-channel 8-bit pwm core with pair joining, avalon-mm register slave
// assumes port data/direction come from logic on SYS_CLK; mode pin is async
//
// The implementer's own choice: the Avalon-MM interface to the registers.

module fcpwm_core (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // avalon-mm slave
  input wire logic [8:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // mode strap and general-purpose port
  input wire logic SPECIAL_MODE,
  input wire logic [3:0] PORT_DIR,
  input wire logic [3:0] PORT_DATA,
  // port p pins
  output fcpwm_pkg::fcpwm_pins_s PWM_PINS
);

  // clock a/b tick: code n fires once per 2^n bus cycles
  function automatic logic pre_tick(input logic [2:0] code, input logic [6:0] pres);
    logic [6:0] mask;
    mask = 7'((8'h01 << code) - 8'h01);
    pre_tick = ((pres & mask) == mask);
  endfunction
  // one channel clock step of counter, direction and output
  function automatic fcpwm_pkg::fcpwm_step_s step(
    input logic [15:0] c,
    input logic [15:0] p,
    input logic [15:0] d,
    input logic down,
    input logic centre,
    input logic pol
  );
    fcpwm_pkg::fcpwm_step_s r;
    r.load = 1'b0;
    r.down = down;
    r.cnt = c + 16'h0001;
    if (!centre) begin
      r.down = 1'b0;
      if (c >= p) begin
        r.cnt = 16'h0000;
        r.load = 1'b1;
      end
    end else if (!down) begin
      if (c >= p) begin
        if (c == 16'h0000) begin
          r.cnt = 16'h0000;
          r.load = 1'b1;
        end else begin
          r.cnt = c - 16'h0001;
          r.down = 1'b1;
        end
      end
    end else begin
      r.cnt = c - 16'h0001;
      if (c <= 16'h0001) begin
        r.cnt = 16'h0000;
        r.down = 1'b0;
        r.load = 1'b1;
      end
    end
    // rising half matches at duty, falling half one count above
    r.out = pol ^ ((d < p) && ((centre && !r.down) ? (r.cnt >= d) : (r.cnt > d)));
    return r;
  endfunction

  fcpwm_pkg::fcpwm_bus_e bus_state_reg;
  logic [7:0] clk_cfg_reg, sel_pol_reg;
  logic [3:0] en_reg, down_reg, out_reg, started_reg;
  logic [6:0] pres_reg;
  logic [4:0] ctrl_reg;
  logic [7:0] scale_reg [fcpwm_pkg::NPAIR], scnt_reg [fcpwm_pkg::NPAIR];
  logic [1:0] sdiv_reg;
  logic [7:0] cnt_reg [fcpwm_pkg::NCH], per_buf_reg [fcpwm_pkg::NCH], per_act_reg [fcpwm_pkg::NCH];
  logic [7:0] dty_buf_reg [fcpwm_pkg::NCH], dty_act_reg [fcpwm_pkg::NCH];
  logic sm_meta_reg, sm_sync_reg;
  logic [7:0] cnt_next [fcpwm_pkg::NCH];
  logic [3:0] down_next, out_next, load_next, ch_tick, en_eff, pin_own, wr_cnt, wr_per, wr_dty;
  logic [1:0] wr_scale, join_w, base_tick, s_tick;
  logic [6:0] idx;
  logic [7:0] wd, rd_byte;
  logic acc_wr, any_en, centre;
  // shared decode
  assign idx = ADDRESS[8:fcpwm_pkg::ADDR_LSB];
  assign wd = WRITEDATA[7:0];
  assign acc_wr = (bus_state_reg == fcpwm_pkg::BUS_ANSWER) && WRITE && BYTEENABLE[0];
  assign join_w[0] = clk_cfg_reg[fcpwm_pkg::LOWER_JOIN_BIT];
  assign join_w[1] = clk_cfg_reg[fcpwm_pkg::UPPER_JOIN_BIT];
  assign any_en = |en_reg;
  assign centre = ctrl_reg[fcpwm_pkg::CENTRE_BIT];
  // clock a and b from the prescaler, stopped with it
  assign base_tick[0] = any_en && pre_tick(clk_cfg_reg[fcpwm_pkg::CLKA_LSB +: 3], pres_reg);
  assign base_tick[1] = any_en && pre_tick(clk_cfg_reg[fcpwm_pkg::CLKB_LSB +: 3], pres_reg);
  // per-channel strobes, clocks and ownership
  always_comb begin
    wr_scale[0] = acc_wr && (idx == fcpwm_pkg::IDX_SCALE_LO);
    wr_scale[1] = acc_wr && (idx == fcpwm_pkg::IDX_SCALE_HI);
    for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
      wr_cnt[i] = acc_wr && (idx == 7'(fcpwm_pkg::IDX_CNT_BASE + i));
      wr_per[i] = acc_wr && (idx == 7'(fcpwm_pkg::IDX_PER_BASE + i));
      wr_dty[i] = acc_wr && (idx == 7'(fcpwm_pkg::IDX_DTY_BASE + i));
      // low byte of a joined pair follows the high channel's enable
      en_eff[i] = (join_w[i / 2] && i[0]) ? en_reg[i - 1] : en_reg[i];
      pin_own[i] = en_reg[i] && !(join_w[i / 2] && i[0]);
      ch_tick[i] = sel_pol_reg[fcpwm_pkg::SEL_LSB + i] ? s_tick[i / 2] : base_tick[i / 2];
    end
  end
  // counter engines, 8-bit alone or 16-bit when joined
  always_comb begin
    fcpwm_pkg::fcpwm_step_s res;
    logic [15:0] c16, p16, d16;
    logic jn;
    int lo;
    res = '0;
    c16 = 16'h0000;
    p16 = 16'h0000;
    d16 = 16'h0000;
    jn = 1'b0;
    lo = 0;
    for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
      cnt_next[i] = cnt_reg[i];
      down_next[i] = down_reg[i];
      out_next[i] = out_reg[i];
      load_next[i] = 1'b0;
    end
    for (int u = 0; u < fcpwm_pkg::NCH; u++) begin
      if (!(join_w[u / 2] && u[0])) begin
        jn = join_w[u / 2];
        lo = jn ? u + 1 : u;
        c16 = jn ? {cnt_reg[u], cnt_reg[lo]} : {fcpwm_pkg::ZERO8, cnt_reg[u]};
        p16 = jn ? {per_act_reg[u], per_act_reg[lo]} : {fcpwm_pkg::ZERO8, per_act_reg[u]};
        d16 = jn ? {dty_act_reg[u], dty_act_reg[lo]} : {fcpwm_pkg::ZERO8, dty_act_reg[u]};
        res = step(c16, p16, d16, down_reg[u], centre, sel_pol_reg[u]);
        if (ch_tick[lo] && en_reg[u]) begin
          cnt_next[u] = jn ? res.cnt[15:8] : res.cnt[7:0];
          cnt_next[lo] = res.cnt[7:0];
          down_next[u] = res.down;
          out_next[u] = res.out;
          load_next[u] = res.load;
          load_next[lo] = res.load;
        end
      end
    end
  end
  // two-flop synchroniser for the special-mode strap
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sm_meta_reg <= 1'b0;
      sm_sync_reg <= 1'b0;
    end else begin
      sm_meta_reg <= SPECIAL_MODE;
      sm_sync_reg <= sm_meta_reg;
    end
  end
  // bus handshake, one wait cycle then answer
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_state_reg <= fcpwm_pkg::BUS_IDLE;
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h0000_0000;
    end else begin
      unique case (bus_state_reg)
        fcpwm_pkg::BUS_IDLE: begin
          if (READ || WRITE) begin
            bus_state_reg <= fcpwm_pkg::BUS_ANSWER;
            WAITREQUEST <= 1'b0;
            READDATA <= READ ? {24'h00_0000, rd_byte} : READDATA; // writes leave read data alone
          end
        end
        fcpwm_pkg::BUS_ANSWER: begin
          bus_state_reg <= fcpwm_pkg::BUS_IDLE;
          WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end
  // read mux, unmapped reads return zero
  always_comb begin
    rd_byte = fcpwm_pkg::ZERO8;
    unique case (idx)
      fcpwm_pkg::IDX_CLK_CFG: rd_byte = clk_cfg_reg;
      fcpwm_pkg::IDX_SEL_POL: rd_byte = sel_pol_reg;
      fcpwm_pkg::IDX_CHAN_EN: rd_byte = {4'h0, en_reg};
      fcpwm_pkg::IDX_PRES_CNT: rd_byte = {1'b0, pres_reg};
      fcpwm_pkg::IDX_SCALE_LO: rd_byte = scale_reg[0];
      fcpwm_pkg::IDX_SCNT_LO: rd_byte = scnt_reg[0];
      fcpwm_pkg::IDX_SCALE_HI: rd_byte = scale_reg[1];
      fcpwm_pkg::IDX_SCNT_HI: rd_byte = scnt_reg[1];
      fcpwm_pkg::IDX_CTRL: rd_byte = {3'h0, ctrl_reg};
      default: begin
        for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
          if (idx == 7'(fcpwm_pkg::IDX_CNT_BASE + i)) begin
            rd_byte = cnt_reg[i];
          end
          if (idx == 7'(fcpwm_pkg::IDX_PER_BASE + i)) begin
            rd_byte = per_buf_reg[i];
          end
          if (idx == 7'(fcpwm_pkg::IDX_DTY_BASE + i)) begin
            rd_byte = dty_buf_reg[i];
          end
        end
      end
    endcase
  end
  // control registers, cleared by reset
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clk_cfg_reg <= fcpwm_pkg::ZERO8;
      sel_pol_reg <= fcpwm_pkg::ZERO8;
      en_reg <= 4'h0;
      ctrl_reg <= 5'h00;
    end else begin
      if (acc_wr && (idx == fcpwm_pkg::IDX_CLK_CFG)) begin
        clk_cfg_reg <= wd;
      end
      if (acc_wr && (idx == fcpwm_pkg::IDX_SEL_POL)) begin
        sel_pol_reg <= wd;
      end
      if (acc_wr && (idx == fcpwm_pkg::IDX_CHAN_EN)) begin
        en_reg <= wd[3:0];
      end
      if (acc_wr && (idx == fcpwm_pkg::IDX_CTRL)) begin
        ctrl_reg <= wd[4:0];
      end
    end
  end
  // free-running prescaler, idle when no channel runs
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pres_reg <= 7'h00;
    end else if (acc_wr && (idx == fcpwm_pkg::IDX_PRES_CNT) && sm_sync_reg) begin
      pres_reg <= wd[6:0];
    end else if (any_en) begin
      pres_reg <= pres_reg + 7'h01;
    end
  end
  // scaled clocks, base divided by scale+1 then by two
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scale_reg <= '{default: fcpwm_pkg::ZERO8};
      scnt_reg <= '{default: fcpwm_pkg::ZERO8};
      sdiv_reg <= 2'h0;
    end else begin
      for (int k = 0; k < fcpwm_pkg::NPAIR; k++) begin
        if (wr_scale[k]) begin
          scale_reg[k] <= wd;
          scnt_reg[k] <= wd;
        end else if (base_tick[k]) begin
          if (scnt_reg[k] == fcpwm_pkg::ZERO8) begin
            scnt_reg[k] <= scale_reg[k];
            sdiv_reg[k] <= ~sdiv_reg[k];
          end else begin
            scnt_reg[k] <= scnt_reg[k] - 8'h01;
          end
        end
      end
    end
  end
  assign s_tick[0] = base_tick[0] && (scnt_reg[0] == fcpwm_pkg::ZERO8) && sdiv_reg[0];
  assign s_tick[1] = base_tick[1] && (scnt_reg[1] == fcpwm_pkg::ZERO8) && sdiv_reg[1];
  // channel counters, direction and output level
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= '{default: fcpwm_pkg::ZERO8};
      down_reg <= 4'h0;
      out_reg <= 4'h0;
    end else begin
      for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
        if (wr_cnt[i]) begin
          cnt_reg[i] <= fcpwm_pkg::ZERO8;
          down_reg[i] <= 1'b0;
          out_reg[i] <= sel_pol_reg[i];
        end else begin
          cnt_reg[i] <= cnt_next[i];
          down_reg[i] <= down_next[i];
          out_reg[i] <= out_next[i];
        end
      end
    end
  end
  // double-buffered period and duty
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      per_buf_reg <= '{default: fcpwm_pkg::PER_RST};
      per_act_reg <= '{default: fcpwm_pkg::PER_RST};
      dty_buf_reg <= '{default: fcpwm_pkg::DTY_RST};
      dty_act_reg <= '{default: fcpwm_pkg::DTY_RST};
    end else begin
      for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
        if (wr_per[i]) begin
          per_buf_reg[i] <= wd;
        end
        if (wr_dty[i]) begin
          dty_buf_reg[i] <= wd;
        end
        if (wr_per[i] && !en_eff[i]) begin
          per_act_reg[i] <= wd;
        end else if (load_next[i] || wr_cnt[i] || !en_eff[i]) begin
          per_act_reg[i] <= per_buf_reg[i];
        end
        if (wr_dty[i] && !en_eff[i]) begin
          dty_act_reg[i] <= wd;
        end else if (load_next[i] || wr_cnt[i] || !en_eff[i]) begin
          dty_act_reg[i] <= dty_buf_reg[i];
        end
      end
    end
  end
  // first channel clock after enable releases the waveform
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      started_reg <= 4'h0;
    end else begin
      for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
        if (!en_reg[i]) begin
          started_reg[i] <= 1'b0;
        end else if (ch_tick[(join_w[i / 2] && !i[0]) ? i + 1 : i]) begin
          started_reg[i] <= 1'b1;
        end
      end
    end
  end
  // pin mux, pwm overrides port while enabled, except on the low-byte pin of a joined pair
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PWM_PINS <= '0;
    end else begin
      for (int i = 0; i < fcpwm_pkg::NCH; i++) begin
        PWM_PINS.level[i] <= pin_own[i] ? (started_reg[i] ? out_reg[i] : sel_pol_reg[i]) : PORT_DATA[i];
        PWM_PINS.oe[i] <= pin_own[i] || PORT_DIR[i];
      end
    end
  end
endmodule

// ### fcpwm_pkg.sv
// constants, field layout and carrier types of the four-channel pwm core
// assumes a single 50 MHz bus clock and a 32-bit avalon-mm master
package fcpwm_pkg;
  // channel count and widths
  localparam int NCH = 4;
  localparam int NPAIR = 2;
  localparam int ADDR_LSB = 2;
  // register indexes, byte address is four times the index
  localparam logic [6:0] IDX_CLK_CFG = 7'h40;
  localparam logic [6:0] IDX_SEL_POL = 7'h41;
  localparam logic [6:0] IDX_CHAN_EN = 7'h42;
  localparam logic [6:0] IDX_PRES_CNT = 7'h43;
  localparam logic [6:0] IDX_SCALE_LO = 7'h44;
  localparam logic [6:0] IDX_SCNT_LO = 7'h45;
  localparam logic [6:0] IDX_SCALE_HI = 7'h46;
  localparam logic [6:0] IDX_SCNT_HI = 7'h47;
  localparam logic [6:0] IDX_CNT_BASE = 7'h48;
  localparam logic [6:0] IDX_PER_BASE = 7'h4C;
  localparam logic [6:0] IDX_DTY_BASE = 7'h50;
  localparam logic [6:0] IDX_CTRL = 7'h54;
  // field positions
  localparam int UPPER_JOIN_BIT = 7;
  localparam int LOWER_JOIN_BIT = 6;
  localparam int CLKA_LSB = 3;
  localparam int CLKB_LSB = 0;
  localparam int SEL_LSB = 4;
  localparam int CENTRE_BIT = 3;
  // reset values
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] PER_RST = 8'hFF;
  localparam logic [7:0] DTY_RST = 8'hFF;
  // bus handshake states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } fcpwm_bus_e;
  // port p pin drive
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } fcpwm_pins_s;
  // result of one counter step
  typedef struct packed {
    logic load;
    logic down;
    logic out;
    logic [15:0] cnt;
  } fcpwm_step_s;
endpackage

// ### fcpwm_tb.sv
// self-checking bench for the pwm core: registers and measured duty
// assumes a 50 MHz clock and a one-wait avalon-mm slave
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, RST_B, READ, WRITE, SPECIAL_MODE, WAITREQUEST;
  logic [8:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA, seed, pseed;
  logic [3:0] BYTEENABLE, PORT_DIR, PORT_DATA;
  logic [7:0] q, a;
  fcpwm_pkg::fcpwm_pins_s PWM_PINS;
  int fails, tests_run, g_div, g_t, p, d;
  int tbl [8][9] = '{'{1, 0, 0, 1, 0, 0, 7, 2, 1}, '{2, 0, 1, 2, 0, 0, 6, 2, 0}, '{3, 0, 0, 0, 1, 2, 5, 1, 1},
    '{1, 0, 1, 0, 1, 1, 4, 1, 0}, '{0, 0, 0, 0, 0, 0, 5, 5, 0}, '{2, 0, 0, 0, 0, 0, 5, 7, 1},
    '{0, 1, 0, 0, 0, 0, 9, 4, 1}, '{2, 1, 1, 0, 0, 0, 6, 1, 0}};

  fcpwm_core u_fcpwm_core (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .SPECIAL_MODE(SPECIAL_MODE), .PORT_DIR(PORT_DIR), .PORT_DATA(PORT_DATA), .PWM_PINS(PWM_PINS));

  // free-running clock
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // random port direction and data every cycle
  always @(posedge SYS_CLK) begin
    pseed <= xs(pseed);
    PORT_DIR <= pseed[3:0];
    PORT_DATA <= pseed[7:4];
  end

  // high cycles per period in channel-clock ticks
  function automatic int highs(int pr, int dt, bit pol, bit c);
    int t, h;
    t = c ? 2 * pr : pr + 1;
    h = (dt < pr) ? (c ? 2 * (pr - dt) : pr - dt) : 0;
    return pol ? t - h : h;
  endfunction

  function automatic logic [6:0] ix(input logic [6:0] b, input int o);
    return b + 7'(o);
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d of %0d comparisons", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one bus access, held until wait is seen low
  task bus(input logic wr, input logic [6:0] idx, input logic [7:0] dat, input logic [3:0] be);
    int n;
    @(posedge SYS_CLK);
    ADDRESS <= {idx, 2'b00};
    WRITEDATA <= {24'h000000, dat};
    BYTEENABLE <= be;
    READ <= !wr;
    WRITE <= wr;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 40);
    q = READDATA[7:0];
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (n >= 40) begin
      fails++;
      $display("FAIL %0t bus answer timed out", $time);
      give_verdict;
    end
  endtask

  task wr(input logic [6:0] idx, input logic [7:0] dat);
    bus(1'b1, idx, dat, 4'hF);
  endtask

  task rdc(input logic [6:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hF);
    chk({24'h000000, q}, {24'h000000, e});
  endtask

  // count pin highs over two whole periods
  task meas(input int ch, input int e);
    int cnt;
    repeat (2 * g_t + 8) @(posedge SYS_CLK);
    cnt = 0;
    repeat (2 * g_t) begin
      @(negedge SYS_CLK);
      cnt += (PWM_PINS.level[ch] === 1'b1);
    end
    chk(cnt, e);
    chk({31'h0, PWM_PINS.oe[ch]}, 32'h1);
  endtask

  // configure while disabled, clear counter last, enable, measure
  task run_case(input int ch, input bit j, input bit c, input int code, input bit sel, input int sc,
      input int pr, input int dt, input bit pol);
    wr(fcpwm_pkg::IDX_CHAN_EN, 8'h00);
    wr(fcpwm_pkg::IDX_CTRL, {4'h0, c, 3'h0});
    wr(fcpwm_pkg::IDX_CLK_CFG, {j && ch == 2, j && ch == 0, code[2:0], code[2:0]});
    wr(fcpwm_pkg::IDX_SEL_POL, {{4{sel}}, {4{pol}}});
    wr(fcpwm_pkg::IDX_SCALE_LO, sc[7:0]);
    wr(fcpwm_pkg::IDX_SCALE_HI, sc[7:0]);
    wr(ix(fcpwm_pkg::IDX_PER_BASE, ch + j), pr[7:0]);
    wr(ix(fcpwm_pkg::IDX_DTY_BASE, ch + j), dt[7:0]);
    if (j) begin
      wr(ix(fcpwm_pkg::IDX_PER_BASE, ch), 8'h00);
      wr(ix(fcpwm_pkg::IDX_DTY_BASE, ch), 8'h00);
    end
    wr(ix(fcpwm_pkg::IDX_CNT_BASE, ch + j), 8'h00);
    wr(ix(fcpwm_pkg::IDX_CNT_BASE, ch), 8'h00);
    wr(fcpwm_pkg::IDX_CHAN_EN, 8'(1 << ch));
    g_div = (1 << code) * (sel ? 2 * (sc + 1) : 1);
    g_t = (c ? 2 * pr : pr + 1) * g_div;
    meas(ch, 2 * highs(pr, dt, pol, c) * g_div);
  endtask

  // main sequence
  initial begin
    RST_B = 1'b0;
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = 9'h000;
    WRITEDATA = 32'h00000000;
    BYTEENABLE = 4'h0;
    SPECIAL_MODE = 1'b0;
    PORT_DIR = 4'h0;
    PORT_DATA = 4'h0;
    seed = 32'h02E3;
    pseed = 32'h02E3;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(ix(fcpwm_pkg::IDX_CLK_CFG, i), 8'h00);
    rdc(fcpwm_pkg::IDX_PER_BASE, 8'hFF);
    rdc(fcpwm_pkg::IDX_DTY_BASE, 8'hFF);
    seed = xs(seed);
    wr(fcpwm_pkg::IDX_SEL_POL, seed[7:0]);
    rdc(fcpwm_pkg::IDX_SEL_POL, seed[7:0]);
    bus(1'b1, fcpwm_pkg::IDX_SEL_POL, ~seed[7:0], 4'h0);
    rdc(fcpwm_pkg::IDX_SEL_POL, seed[7:0]);
    rdc(7'h60, 8'h00);
    wr(fcpwm_pkg::IDX_PRES_CNT, 8'hD5);
    rdc(fcpwm_pkg::IDX_PRES_CNT, 8'h00);
    SPECIAL_MODE <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    wr(fcpwm_pkg::IDX_PRES_CNT, 8'hD5);
    rdc(fcpwm_pkg::IDX_PRES_CNT, 8'h55);
    rdc(fcpwm_pkg::IDX_PRES_CNT, 8'h55);
    SPECIAL_MODE <= 1'b0;
    for (int k = 0; k < 8; k++) run_case(0, 0, 0, k, 0, 0, 3, 1, 0);
    foreach (tbl[r]) run_case(tbl[r][0], tbl[r][1], tbl[r][2], tbl[r][3], tbl[r][4], tbl[r][5],
      tbl[r][6], tbl[r][7], tbl[r][8]);
    for (int r = 0; r < 4; r++) begin
      seed = xs(seed);
      p = 2 + seed[11:8] % 12;
      d = seed[19:12] % (p + 2);
      run_case(seed[1:0], 0, seed[2], seed[4:3], seed[5], 1, p, d, seed[6]);
    end
    run_case(0, 0, 0, 0, 0, 0, 9, 3, 0);
    wr(fcpwm_pkg::IDX_DTY_BASE, 8'h06);
    meas(0, 2 * highs(9, 6, 0, 0));
    bus(1'b0, fcpwm_pkg::IDX_PRES_CNT, 8'h00, 4'hF);
    a = q;
    bus(1'b0, fcpwm_pkg::IDX_PRES_CNT, 8'h00, 4'hF);
    chk({31'h0, a == q}, 32'h0);
    give_verdict;
  end
endmodule
